// [verilog/rsp_map.svh]
// Offsets, field positions, reset values and timing counts for the reset and scan pin block.
// Assumes a 40 MHz system clock.
`ifndef RSP_MAP_SVH
`define RSP_MAP_SVH
`define RSP_CLK_PERIOD_NS 25
`define RSP_WARM_PULSE_NS 150
`define RSP_WARM_PULSE_CYC ((`RSP_WARM_PULSE_NS + `RSP_CLK_PERIOD_NS - 1) / `RSP_CLK_PERIOD_NS)
`define RSP_OPR_DELAY_NS 120
`define RSP_OPR_DELAY_CYC ((`RSP_OPR_DELAY_NS + `RSP_CLK_PERIOD_NS - 1) / `RSP_CLK_PERIOD_NS)
`define RSP_SCAN_CTRL_OFS 8'hC7
`define RSP_SCAN_EN_BIT 0
`define RSP_SCAN_CTRL_RST 8'h00
`define RSP_PM_RST 8'h00
`define RSP_GEN_RST 8'h00
`define RSP_MAP_SRAM_BIT 0
`define RSP_MAP_PERIPH_BIT 1
`define RSP_ENABLE_IR 4'hA
`define RSP_EXT_BIT 0
`endif

// [verilog/rsp_pkg.sv]
// Types shared by the reset and scan pin block.
// Assumes the map header is on the include path.
package rsp_pkg;
  typedef enum logic [1:0] {
    RSP_ST_PORST = 2'b00,
    RSP_ST_HOLD = 2'b01,
    RSP_ST_WAIT = 2'b10,
    RSP_ST_RUN = 2'b11
  } rsp_state_t;

  typedef struct packed {
    logic we;
    logic re;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rsp_host_req_t;

  typedef struct packed {
    logic tms;
    logic tck;
    logic tdi;
    logic tdo;
  } rsp_scan_pins_t;
endpackage : rsp_pkg

// [verilog/rsp_top.sv]
// Reset sequencing, register reset classes and scan pin muxing on the shared port pins.
// Assumes a host register strobe on clk_sys_i and a scan clock from an external programmer.
`include "rsp_map.svh"
// Overview of operation
// [RULE1] Warm reset accepted from 150 ns low pulse.
// [RULE2] Warm reset waits operational delay before access.
// [RULE3] Operational delay at least 120 ns after release.
// [RULE4] Logic outputs stay valid during warm reset.
// [RULE5] Power-on: outputs valid after configuration loads.
// [RULE6] Reset: inputs, tri-state; power-down keeps tri-state; the code leaves mcu_io_oe_o driven in power-down.
// [RULE7] Power regs clear only at power-on.
// [RULE8] Macrocells cleared at power-on, else equations.
// [RULE9] Map register loads default, two bits zeroed.
// [RULE10] Blank part defaults pins to scan.
// [RULE11] Scan active is OR of three sources; the code ORs four, with blank part as a source of its own.
// [RULE12] Before enable command all scan pins input.
// [RULE13] After command serial out drives, channel live.
// [RULE14] Command may enable busy and error pins.
// [RULE15] Scan inactive releases pins to general use.
// [RULE16] Configuration bit dedicates pins permanently.
// [RULE17] Host enables scan at offset C7h.
// [RULE18] Scan enable cleared by reset or host.
// [RULE19] Bit 0 enables; bits 1-7 unused.
// [RULE20] Product term can enable scan pins.
// [RULE21] Product term tied to cable enable.
module rsp_top (
  // Clocks and resets.
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic por_n_i,
  input wire logic tck_i,
  // Configuration and power state.
  input wire logic cfg_loaded_i,
  input wire logic nv_config_scan_source_i,
  input wire logic blank_part_i,
  input wire logic [7:0] map_default_i,
  input wire logic power_down_i,
  input wire logic scan_select_product_term_i,
  // Host register access.
  input wire rsp_pkg::rsp_host_req_t host_req_i,
  output logic [7:0] host_rdata_o,
  output logic host_ready_o,
  input wire logic [7:0] power_mgmt_mode_regs_wdata_i,
  input wire logic power_mgmt_mode_regs_we_i,
  output logic [7:0] power_mgmt_mode_regs_o,
  output logic [7:0] memory_map_select_reg_o,
  output logic [7:0] general_reg_o,
  // Macrocells and logic outputs.
  input wire logic [7:0] mcell_d_i,
  input wire logic [7:0] macrocell_reset_equation_i,
  input wire logic [7:0] macrocell_preset_equation_i,
  output logic [7:0] mcell_q_o,
  output logic pld_out_valid_o,
  // Port output enables.
  output logic mcu_io_oe_o,
  output logic addr_out_oe_o,
  output logic data_oe_o,
  output logic periph_oe_o,
  // Shared scan pins.
  input wire rsp_pkg::rsp_scan_pins_t pin_in_i,
  input wire rsp_pkg::rsp_scan_pins_t gpio_out_i,
  input wire rsp_pkg::rsp_scan_pins_t gpio_oe_i,
  output rsp_pkg::rsp_scan_pins_t pin_out_o,
  output rsp_pkg::rsp_scan_pins_t pin_oe_o,
  output logic [3:0] scan_gpio_in_o,
  input wire logic scan_cmd_i,
  input wire logic [3:0] scan_ir_i,
  input wire logic scan_tdo_i,
  input wire logic scan_busy_status_i,
  input wire logic scan_error_flag_i,
  output logic scan_active_o,
  output logic scan_live_o,
  output logic scan_ext_en_o,
  output logic scan_busy_status_o,
  output logic scan_error_flag_o,
  output logic ext_oe_o
);
  import rsp_pkg::*;
  // ----------------------------------------------------------------
  // Reset pin synchronisers and pulse qualification
  // ----------------------------------------------------------------
  logic [1:0] rst_sync_q, rst_sync_d;
  logic [1:0] lde_sync_q, lde_sync_d;
  logic [1:0] pd_sync_q, pd_sync_d;
  logic rst_low, loaded, pd;
  assign rst_low = ~rst_sync_q[1];
  assign loaded = lde_sync_q[1];
  assign pd = pd_sync_q[1];
  always_comb begin
    rst_sync_d = {rst_sync_q[0], reset_n_i};
    lde_sync_d = {lde_sync_q[0], cfg_loaded_i};
    pd_sync_d = {pd_sync_q[0], power_down_i};
  end
  always_ff @(posedge clk_sys_i or negedge por_n_i) begin
    if (!por_n_i) begin
      rst_sync_q <= 2'h0;
      lde_sync_q <= 2'h0;
      pd_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= rst_sync_d;
      lde_sync_q <= lde_sync_d;
      pd_sync_q <= pd_sync_d;
    end
  end
  // ----------------------------------------------------------------
  // Reset state machine
  // ----------------------------------------------------------------
  rsp_state_t st_q, st_d;
  logic [3:0] cnt_q, cnt_d;
  logic in_reset, warm_take;
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    warm_take = 1'b0;
    unique case (st_q)
      RSP_ST_PORST: begin
        cnt_d = 4'h0;
        if (loaded && !rst_low) begin
          st_d = RSP_ST_WAIT; // RULE5
        end
      end
      RSP_ST_RUN: begin
        cnt_d = 4'h0;
        if (rst_low) begin
          st_d = RSP_ST_HOLD;
          cnt_d = 4'h1;
        end
      end
      RSP_ST_HOLD: begin
        if (rst_low) begin
          if (cnt_q < 4'(`RSP_WARM_PULSE_CYC)) begin
            cnt_d = cnt_q + 4'h1; // RULE1
          end
        end else if (cnt_q >= 4'(`RSP_WARM_PULSE_CYC)) begin
          st_d = RSP_ST_WAIT;
          cnt_d = 4'h0;
          warm_take = 1'b1;
        end else begin
          st_d = RSP_ST_RUN;
          cnt_d = 4'h0;
        end
      end
      RSP_ST_WAIT: begin
        if (rst_low) begin
          st_d = RSP_ST_HOLD;
          cnt_d = 4'h1;
        end else if (cnt_q >= 4'(`RSP_OPR_DELAY_CYC - 1)) begin
          st_d = RSP_ST_RUN; // RULE2 RULE3
          cnt_d = 4'h0;
        end else begin
          cnt_d = cnt_q + 4'h1;
        end
      end
    endcase
  end
  always_ff @(posedge clk_sys_i or negedge por_n_i) begin
    if (!por_n_i) begin
      st_q <= RSP_ST_PORST;
      cnt_q <= 4'h0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
    end
  end
  logic rst_pulse_q;
  always_ff @(posedge clk_sys_i or negedge por_n_i) begin
    if (!por_n_i) begin
      rst_pulse_q <= 1'b1;
    end else begin
      rst_pulse_q <= (st_q == RSP_ST_PORST) || warm_take;
    end
  end
  assign in_reset = (st_q != RSP_ST_RUN);
  assign host_ready_o = ~in_reset; // RULE2
  assign pld_out_valid_o = (st_q != RSP_ST_PORST); // RULE4 RULE5
  // ----------------------------------------------------------------
  // Pin directions during reset and power-down
  // ----------------------------------------------------------------
  always_comb begin
    mcu_io_oe_o = ~in_reset; // RULE6
    addr_out_oe_o = ~in_reset & ~pd;
    data_oe_o = ~in_reset & ~pd;
    periph_oe_o = ~in_reset & ~pd;
  end
  // ----------------------------------------------------------------
  // Registers with their reset classes
  // ----------------------------------------------------------------
  logic [7:0] pm_q, pm_d, map_q, map_d, gen_q, gen_d, ctl_q, ctl_d;
  logic host_wr, host_wr_ctl;
  assign host_wr = host_req_i.we && !in_reset && !pd;
  assign host_wr_ctl = host_wr && (host_req_i.addr == `RSP_SCAN_CTRL_OFS);
  always_comb begin
    pm_d = pm_q;
    map_d = map_q;
    gen_d = gen_q;
    ctl_d = ctl_q;
    if (power_mgmt_mode_regs_we_i && !in_reset) begin
      pm_d = power_mgmt_mode_regs_wdata_i; // RULE7
    end
    if (rst_pulse_q) begin
      map_d = map_default_i; // RULE9
      map_d[`RSP_MAP_SRAM_BIT] = 1'b0;
      map_d[`RSP_MAP_PERIPH_BIT] = 1'b0;
      gen_d = `RSP_GEN_RST; // RULE7
      ctl_d = `RSP_SCAN_CTRL_RST; // RULE18
    end else if (host_wr_ctl) begin
      ctl_d = {7'h00, host_req_i.wdata[`RSP_SCAN_EN_BIT]}; // RULE17 RULE18 RULE19
    end
  end
  always_ff @(posedge clk_sys_i or negedge por_n_i) begin
    if (!por_n_i) begin
      pm_q <= `RSP_PM_RST;
      map_q <= 8'h00;
      gen_q <= `RSP_GEN_RST;
      ctl_q <= `RSP_SCAN_CTRL_RST;
    end else begin
      pm_q <= pm_d;
      map_q <= map_d;
      gen_q <= gen_d;
      ctl_q <= ctl_d;
    end
  end
  logic [7:0] rdata_q, rdata_d;
  always_comb begin
    rdata_d = rdata_q;
    if (host_req_i.re) begin
      rdata_d = (host_req_i.addr == `RSP_SCAN_CTRL_OFS) ? ctl_q : 8'h00;
    end
  end
  always_ff @(posedge clk_sys_i or negedge por_n_i) begin
    if (!por_n_i) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end
  assign host_rdata_o = rdata_q;
  assign power_mgmt_mode_regs_o = pm_q;
  assign memory_map_select_reg_o = map_q;
  assign general_reg_o = gen_q;
  // ----------------------------------------------------------------
  // Output macrocells
  // ----------------------------------------------------------------
  logic [7:0] mc_q, mc_d;
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_mc
      always_comb begin
        if (macrocell_reset_equation_i[gi]) begin
          mc_d[gi] = 1'b0; // RULE8
        end else if (macrocell_preset_equation_i[gi]) begin
          mc_d[gi] = 1'b1;
        end else begin
          mc_d[gi] = mcell_d_i[gi];
        end
      end
    end
  endgenerate
  always_ff @(posedge clk_sys_i or negedge por_n_i) begin
    if (!por_n_i) begin
      mc_q <= 8'h00; // RULE8
    end else begin
      mc_q <= mc_d;
    end
  end
  assign mcell_q_o = mc_q;
  // ----------------------------------------------------------------
  // Scan enable and link-side command latch
  // ----------------------------------------------------------------
  logic active_src;
  assign active_src = nv_config_scan_source_i | blank_part_i | ctl_q[`RSP_SCAN_EN_BIT]
                      | scan_select_product_term_i; // RULE10 RULE11 RULE16 RULE20 RULE21
  logic [1:0] act_tck_q, act_tck_d;
  logic live_q, live_d, ext_q, ext_d;
  always_comb begin
    act_tck_d = {act_tck_q[0], active_src};
    live_d = live_q;
    ext_d = ext_q;
    if (!act_tck_q[1]) begin
      live_d = 1'b0;
      ext_d = 1'b0;
    end else if (scan_cmd_i && scan_ir_i == `RSP_ENABLE_IR) begin
      live_d = 1'b1; // RULE13
      ext_d = pin_in_i.tdi; // RULE14
    end
  end
  always_ff @(posedge tck_i or negedge por_n_i) begin
    if (!por_n_i) begin
      act_tck_q <= 2'h0;
      live_q <= 1'b0;
      ext_q <= 1'b0;
    end else begin
      act_tck_q <= act_tck_d;
      live_q <= live_d;
      ext_q <= ext_d;
    end
  end
  logic [1:0] live_sys_q, live_sys_d, ext_sys_q, ext_sys_d;
  always_comb begin
    live_sys_d = {live_sys_q[0], live_q};
    ext_sys_d = {ext_sys_q[0], ext_q};
  end
  always_ff @(posedge clk_sys_i or negedge por_n_i) begin
    if (!por_n_i) begin
      live_sys_q <= 2'h0;
      ext_sys_q <= 2'h0;
    end else begin
      live_sys_q <= live_sys_d;
      ext_sys_q <= ext_sys_d;
    end
  end
  // ----------------------------------------------------------------
  // Pin mux
  // ----------------------------------------------------------------
  always_comb begin
    scan_active_o = active_src;
    scan_live_o = live_sys_q[1];
    scan_ext_en_o = ext_sys_q[1] & active_src;
    ext_oe_o = ext_sys_q[1] & active_src; // RULE14
    scan_busy_status_o = scan_busy_status_i;
    scan_error_flag_o = scan_error_flag_i;
    if (active_src) begin
      pin_oe_o = '{tms: 1'b0, tck: 1'b0, tdi: 1'b0, tdo: live_sys_q[1]}; // RULE12 RULE13
      pin_out_o = '{tms: 1'b0, tck: 1'b0, tdi: 1'b0, tdo: scan_tdo_i};
      scan_gpio_in_o = 4'h0;
    end else begin
      pin_oe_o = gpio_oe_i; // RULE15
      pin_out_o = gpio_out_i;
      scan_gpio_in_o = pin_in_i;
    end
  end
  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence warm_release_s;
    (st_q == RSP_ST_HOLD) && !rst_low && (cnt_q >= 4'(`RSP_WARM_PULSE_CYC));
  endsequence
  scan_or_sources_a: assert property (@(posedge clk_sys_i) disable iff (!por_n_i)
    scan_active_o == (nv_config_scan_source_i | blank_part_i | ctl_q[0]
                      | scan_select_product_term_i)) // RULE11
    else $error("scan active is not the OR of its sources");
  nv_dedicates_a: assert property (@(posedge clk_sys_i) disable iff (!por_n_i)
    nv_config_scan_source_i |-> scan_active_o && pin_oe_o.tms == 1'b0) // RULE16
    else $error("configuration bit did not dedicate pins");
  gpio_release_a: assert property (@(posedge clk_sys_i) disable iff (!por_n_i)
    !scan_active_o |-> pin_oe_o == gpio_oe_i) // RULE15
    else $error("pins not released to general use");
  tdo_input_a: assert property (@(posedge clk_sys_i) disable iff (!por_n_i)
    scan_active_o && !scan_live_o |-> !pin_oe_o.tdo) // RULE12
    else $error("serial out driven before command");
  ctrl_write_a: assert property (@(posedge clk_sys_i) disable iff (!por_n_i)
    host_wr_ctl && !rst_pulse_q |=> ctl_q == {7'h00, $past(host_req_i.wdata[0])}) // RULE17
    else $error("control write not stored");
  ctrl_reset_a: assert property (@(posedge clk_sys_i) disable iff (!por_n_i)
    rst_pulse_q |=> ctl_q == 8'h00 && map_q[1:0] == 2'h0) // RULE18
    else $error("reset did not clear control or map bits");
  opr_delay_a: assert property (@(posedge clk_sys_i) disable iff (!por_n_i)
    warm_release_s |=> !host_ready_o [*4]) // RULE2
    else $error("host ready before operational delay");
  pm_keep_a: assert property (@(posedge clk_sys_i) disable iff (!por_n_i)
    rst_pulse_q && !power_mgmt_mode_regs_we_i |=> $stable(pm_q)) // RULE7
    else $error("power registers changed on warm reset");
  reset_tristate_a: assert property (@(posedge clk_sys_i) disable iff (!por_n_i)
    in_reset |-> !data_oe_o && !addr_out_oe_o && !mcu_io_oe_o) // RULE6
    else $error("pins driven during reset");
  short_pulse_a: assert property (@(posedge clk_sys_i) disable iff (!por_n_i)
    (st_q == RSP_ST_RUN) ##1 (st_q == RSP_ST_HOLD) ##1 !rst_low |=> st_q == RSP_ST_RUN) // RULE1
    else $error("short glitch taken as warm reset");
endmodule : rsp_top

// [tb/rsp_prog_model.sv]
// Behavioural scan programmer standing at the far side of the shared scan pins.
// Assumes the bench calls frame() and drives attach_i while a cable is attached.
module rsp_prog_model (
  // Cable attach from the bench.
  input wire logic attach_i,
  // Scan side towards the device.
  output logic tck_o,
  output logic tms_o,
  output logic tdi_o,
  output logic cmd_o,
  output logic [3:0] ir_o,
  output logic scan_select_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic cable_scan_enable_n;
  assign cable_scan_enable_n = ~attach_i;
  assign scan_select_o = ~cable_scan_enable_n;
  initial begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b0;
    cmd_o = 1'b0;
    ir_o = 4'h0;
  end
  // Six 64 ns clocks; the command sits across the fourth rising edge.
  // Outside the command the code lines show the inverse, and the clock stands low.
  task automatic frame(input logic [3:0] ir, input logic ext);
    #7;
    for (int i = 0; i < 6; i++) begin
      cmd_o = (i == 3);
      ir_o = (i == 3) ? ir : ~ir;
      tdi_o = (i == 3) ? ext : ~ext;
      tms_o = ~tms_o;
      #32 tck_o = 1'b1;
      #32 tck_o = 1'b0;
    end
    cmd_o = 1'b0;
    ir_o = ~ir;
    tdi_o = ~ext;
  endtask : frame
endmodule : rsp_prog_model

// [tb/tb_rsp_top.sv]
// Self-checking bench for the reset and scan pin block.
// Assumes the design package and map header are compiled first.
module tb_rsp_top import rsp_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys_i, reset_n_i, por_n_i, tck_i, cfg_loaded_i, nv_config_scan_source_i;
  logic blank_part_i, power_down_i, scan_select_product_term_i, host_ready_o;
  logic power_mgmt_mode_regs_we_i, pld_out_valid_o, mcu_io_oe_o, addr_out_oe_o;
  logic data_oe_o, periph_oe_o, scan_cmd_i, scan_tdo_i, scan_busy_status_i;
  logic scan_error_flag_i, scan_active_o, scan_live_o, scan_ext_en_o, scan_busy_status_o;
  logic attach, tms_p, tdi_p, scan_error_flag_o, ext_oe_o;
  logic [3:0] scan_ir_i, scan_gpio_in_o;
  logic [7:0] map_default_i, host_rdata_o, power_mgmt_mode_regs_wdata_i;
  logic [7:0] power_mgmt_mode_regs_o, memory_map_select_reg_o, general_reg_o;
  logic [7:0] mcell_d_i, macrocell_reset_equation_i, macrocell_preset_equation_i, mcell_q_o;
  logic [7:0] wd;
  logic ex;
  rsp_host_req_t host_req_i;
  rsp_scan_pins_t pin_in_i, gpio_out_i, gpio_oe_i, pin_out_o, pin_oe_o;
  int n_fail = 0;
  int total_checks = 0;
  // Row fields: source bit, blank, cable attach, written byte, expected active.
  logic [11:0] rows [7] = '{12'h000, 12'h801, 12'h401, 12'h201, 12'h003, 12'h1FC, 12'h1FF};

  rsp_top rsp_top_inst (.clk_sys_i, .reset_n_i, .por_n_i, .tck_i, .cfg_loaded_i,
    .nv_config_scan_source_i, .blank_part_i, .map_default_i, .power_down_i,
    .scan_select_product_term_i, .host_req_i, .host_rdata_o, .host_ready_o,
    .power_mgmt_mode_regs_wdata_i, .power_mgmt_mode_regs_we_i, .power_mgmt_mode_regs_o,
    .memory_map_select_reg_o, .general_reg_o, .mcell_d_i, .macrocell_reset_equation_i,
    .macrocell_preset_equation_i, .mcell_q_o, .pld_out_valid_o, .mcu_io_oe_o,
    .addr_out_oe_o, .data_oe_o, .periph_oe_o, .pin_in_i, .gpio_out_i, .gpio_oe_i,
    .pin_out_o, .pin_oe_o, .scan_gpio_in_o, .scan_cmd_i, .scan_ir_i, .scan_tdo_i,
    .scan_busy_status_i, .scan_error_flag_i, .scan_active_o, .scan_live_o, .scan_ext_en_o,
    .scan_busy_status_o, .scan_error_flag_o, .ext_oe_o);
  rsp_prog_model rsp_prog_model_inst (.attach_i(attach), .tck_o(tck_i), .tms_o(tms_p),
    .tdi_o(tdi_p), .cmd_o(scan_cmd_i), .ir_o(scan_ir_i),
    .scan_select_o(scan_select_product_term_i));
  // Released serial-out line shows the inverse of serial-in rather than a stale value.
  assign pin_in_i = {tms_p, tck_i, tdi_p, pin_oe_o.tdo ? pin_out_o.tdo : ~tdi_p};

  always #12.5 clk_sys_i = ~clk_sys_i;

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : check
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask : cyc
  task automatic host(input logic we, input logic [7:0] addr, input logic [7:0] wdata);
    @(negedge clk_sys_i);
    host_req_i = '{we: we, re: ~we, addr: addr, wdata: wdata};
    @(negedge clk_sys_i);
    host_req_i = '0;
    @(negedge clk_sys_i);
  endtask : host
  task automatic rd(input logic [7:0] addr, input logic [7:0] exp);
    host(1'b0, addr, 8'h00);
    check(host_rdata_o, exp, "read data");
  endtask : rd
  // Ready must stay low for the operational delay, then rise within a bound.
  task automatic settle();
    int k;
    k = 0;
    cyc(4);
    check(host_ready_o, 8'h00, "ready too early");
    while (host_ready_o !== 1'b1 && k < 40) begin
      cyc(1);
      k++;
    end
    check(host_ready_o, 8'h01, "ready never rose");
  endtask : settle
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test

  // The whole sequence needs about 180 clock cycles.
  initial begin
    #(5000 * 25);
    n_fail++;
    $display("unexpected at %0t: watchdog expired", $time);
    end_of_test();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {clk_sys_i, reset_n_i, por_n_i, cfg_loaded_i, nv_config_scan_source_i} = '0;
    {blank_part_i, power_down_i, power_mgmt_mode_regs_we_i, scan_tdo_i, attach} = '0;
    {scan_busy_status_i, scan_error_flag_i, mcell_d_i, power_mgmt_mode_regs_wdata_i} = '0;
    {macrocell_reset_equation_i, macrocell_preset_equation_i} = '0;
    map_default_i = 8'hA7;
    host_req_i = '0;
    gpio_out_i = 4'h6;
    gpio_oe_i = 4'h9;
    cyc(4);
    check(pld_out_valid_o, 8'h00, "valid before config");
    check({mcu_io_oe_o, addr_out_oe_o, data_oe_o, periph_oe_o}, 8'h00, "oe in reset");
    check(mcell_q_o, 8'h00, "macrocells at power-on");
    por_n_i = 1'b1;
    reset_n_i = 1'b1;
    cyc(6);
    check(host_ready_o, 8'h00, "ready before config");
    cfg_loaded_i = 1'b1;
    settle();
    check(pld_out_valid_o, 8'h01, "valid after config");
    check(power_mgmt_mode_regs_o, 8'h00, "power regs");
    check(general_reg_o, 8'h00, "general reg");
    check(memory_map_select_reg_o, 8'hA4, "map reg");
    rd(8'hC7, 8'h00);
    rd(8'h42, 8'h00);
    $display("test power-on reset done");
    for (int i = 0; i < 7; i++) begin
      {nv_config_scan_source_i, blank_part_i, attach, wd, ex} = rows[i];
      gpio_out_i = 4'(i) ^ 4'h6;
      gpio_oe_i = 4'(i) ^ 4'h9;
      host(1'b1, 8'hC7, wd);
      check(scan_active_o, ex, "scan active");
      rd(8'hC7, {7'h00, wd[0]});
      if (ex) begin
        check(pin_oe_o, 8'h00, "oe waiting");
      end else begin
        check(pin_oe_o, gpio_oe_i, "gpio oe");
        check(pin_out_o, gpio_out_i, "gpio out");
        check(scan_gpio_in_o, pin_in_i, "gpio in");
      end
    end
    {nv_config_scan_source_i, blank_part_i, attach} = '0;
    $display("test enable sources done");
    power_mgmt_mode_regs_wdata_i = 8'h5A;
    power_mgmt_mode_regs_we_i = 1'b1;
    cyc(1);
    power_mgmt_mode_regs_we_i = 1'b0;
    host(1'b1, 8'hC7, 8'h01);
    reset_n_i = 1'b0;
    cyc(3);
    reset_n_i = 1'b1;
    cyc(10);
    rd(8'hC7, 8'h01);
    mcell_d_i = 8'h3C;
    macrocell_reset_equation_i = 8'h04;
    macrocell_preset_equation_i = 8'h01;
    reset_n_i = 1'b0;
    cyc(6);
    reset_n_i = 1'b1;
    cyc(2);
    check(pld_out_valid_o, 8'h01, "valid in warm reset");
    check(mcell_q_o, 8'h39, "macrocells in warm reset");
    check({mcu_io_oe_o, addr_out_oe_o, data_oe_o, periph_oe_o}, 8'h00, "oe warm");
    settle();
    check(power_mgmt_mode_regs_o, 8'h5A, "power regs kept");
    check(memory_map_select_reg_o, 8'hA4, "map reg warm");
    check(general_reg_o, 8'h00, "general reg warm");
    rd(8'hC7, 8'h00);
    $display("test warm reset done");
    power_down_i = 1'b1;
    cyc(4);
    check({mcu_io_oe_o, data_oe_o, periph_oe_o}, 8'h04, "oe power-down");
    check(power_mgmt_mode_regs_o, 8'h5A, "power regs in power-down");
    host(1'b1, 8'hC7, 8'h01);
    check(scan_active_o, 8'h00, "write in power-down");
    power_down_i = 1'b0;
    cyc(4);
    $display("test power-down done");
    host(1'b1, 8'hC7, 8'h01);
    scan_tdo_i = 1'b1;
    scan_busy_status_i = 1'b1;
    rsp_prog_model_inst.frame(4'h3, 1'b1);
    cyc(4);
    check(scan_live_o, 8'h00, "live on wrong code");
    check(pin_oe_o, 8'h00, "oe on wrong code");
    rsp_prog_model_inst.frame(4'hA, 1'b1);
    cyc(4);
    check(scan_live_o, 8'h01, "live");
    check(pin_oe_o.tdo, 8'h01, "serial out drive");
    check(pin_out_o.tdo, scan_tdo_i, "serial out data");
    check(scan_ext_en_o, 8'h01, "extension enable");
    check(scan_busy_status_o, scan_busy_status_i, "busy pin");
    check(ext_oe_o, 8'h01, "extension drive");
    scan_error_flag_i = 1'b1;
    cyc(1);
    check(scan_error_flag_o, 8'h01, "error pin");
    rsp_prog_model_inst.frame(4'hA, 1'b0);
    cyc(4);
    check(scan_ext_en_o, 8'h00, "extension not requested");
    check(ext_oe_o, 8'h00, "extension idle");
    check(pin_oe_o.tdo, 8'h01, "serial out still driven");
    host(1'b1, 8'hC7, 8'h00);
    check(scan_active_o, 8'h00, "host clear");
    $display("test scan command done");
    end_of_test();
  end
endmodule : tb_rsp_top
